// ---- verilog/limit_bank_defines.svh ----
// Purpose: offsets, reset values and limits of the limit/supply bank
// Assumes: included by bare name from design and testbench files
// Notes:   offsets are the command register numbers of the link
`ifndef LIMIT_BANK_DEFINES_SVH
`define LIMIT_BANK_DEFINES_SVH

// register numbers, read command equals the number
`define REGEN_CAP_OFS      4'h3
`define ACCEL_RAMP_OFS     4'h4
`define DECEL_RAMP_OFS     4'h5
`define UV_SHUTDOWN_OFS    4'h6
`define UV_RECOVER_OFS     4'h7
`define OV_RECOVER_OFS     4'h8
`define OV_SHUTDOWN_OFS    4'h9
`define HEATSINK_TEMP_OFS  4'ha
`define BOARD_TEMP_OFS     4'hb

// command byte layout
`define CMD_WRITE_BIT      6
`define CMD_REG_MSB        5
`define BYTE_TOP_BIT       7

// value split over two data bytes
`define VAL_HI_MSB         13
`define VAL_HI_LSB         7
`define VAL_LO_MSB         6

// reset values of the threshold and decel limit registers
`define UV_SHUTDOWN_RST    12'h000
`define UV_RECOVER_RST     12'h000
`define OV_RECOVER_RST     12'h951
`define OV_SHUTDOWN_RST    12'h997
`define DECEL_RAMP_RST     12'h000

// internal ceiling of the over-voltage shutdown level
`define OV_INTERNAL_MAX    12'h997

// heatsink temperature range in degrees
`define HEATSINK_MIN       12'h00a
`define HEATSINK_MAX       12'h050

`endif

// ---- verilog/limit_bank_pkg.sv ----
// Purpose: types shared by the limit/supply register bank
// Assumes: nothing is imported, users write limit_bank_pkg::name
// Notes:   constants live in limit_bank_defines.svh
package limit_bank_pkg;

	// lock settings from the lock register logic
	typedef struct packed {
		logic regen;
		logic accel;
		logic uv_off;
		logic uv_on;
		logic ov_on;
		logic ov_off;
	} lock_s;

	// one byte of the command link
	typedef struct packed {
		logic       valid;
		logic [7:0] data;
	} link_byte_s;

	// command parser states
	typedef enum logic [1:0] {
		ST_CMD,
		ST_DATA_HI,
		ST_DATA_LO,
		ST_SEND_LO
	} parse_state_e;

	typedef logic [11:0] value_t;

endpackage

// ---- verilog/pot_tracked_reg.sv ----
// Purpose: limit register that follows a potentiometer unless overridden
// Assumes: pot value comes from same-clock converter logic
// Notes:   a host write holds until the pot reading moves
`timescale 1ns/100ps

module pot_tracked_reg (
	// clock and reset
	input  wire logic                  clk_in,
	input  wire logic                  rst_in,
	// potentiometer side
	input  wire limit_bank_pkg::value_t pot_in,
	input  wire logic                  lock_in,
	// host side
	input  wire logic                  wr_in,
	input  wire limit_bank_pkg::value_t wr_data_in,
	output limit_bank_pkg::value_t     value_out
);

	limit_bank_pkg::value_t pot_prev_reg;
	logic                   seeded_reg;
	logic                   pot_moved;

	// pot change since last cycle, or first cycle after reset
	assign pot_moved = !seeded_reg || (pot_in != pot_prev_reg);

	// last pot reading and seed flag
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			pot_prev_reg <= 12'h000;
			seeded_reg   <= 1'b0;
		end else begin
			pot_prev_reg <= pot_in;
			seeded_reg   <= 1'b1;
		end
	end

	// value: host write wins, else the seed or an unlocked pot move
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			value_out <= 12'h000;
		end else if (wr_in) begin
			value_out <= wr_data_in;
		end else if (!seeded_reg || (pot_moved && !lock_in)) begin
			value_out <= pot_in;
		end
	end

endmodule

// ---- verilog/limit_supply_bank.sv ----
// Purpose: limit and supply threshold registers behind the command link
// Assumes: link bytes come from a same-clock receiver, one per strobe
// Notes:   values travel as two 7-bit data bytes, high part first
`timescale 1ns/100ps
`include "limit_bank_defines.svh"

// Function
// - values travel as two 7-bit bytes, high first
// - regen cap 12 bits, cmds 0x43/0x03, mirrors pot
// - host write holds until the pot moves
// - lock stops pot overwriting host value
// - limit values revert on restart
// - accel limit cmds 0x44/0x04, mirrors ramp pot
// - decel limit cmds 0x45/0x05, off by default
// - active low shutdown below level 0x46/0x06
// - low supply shutdown updates status
// - leave low state above level 0x47/0x07
// - leave high state below level 0x48/0x08
// - active high shutdown above level 0x49/0x09
// - high supply shutdown updates status
// - thresholds active only when written and locked
// - internal maximum may replace high shutdown level
// - heatsink temperature read-only 0x0A, 10 to 80
// - board temperature read-only 0x0B, low 7 bits
module limit_supply_bank (
	// clock and reset
	input  wire logic                   clk_in,
	input  wire logic                   rst_in,
	// command link, receive side
	input  wire logic [7:0]             rx_byte_in,
	input  wire logic                   rx_valid_in,
	// command link, answer side
	output logic [7:0]                  tx_byte_out,
	output logic                        tx_valid_out,
	// potentiometers and lock settings
	input  wire limit_bank_pkg::value_t  regen_pot_in,
	input  wire limit_bank_pkg::value_t  ramp_pot_in,
	input  wire limit_bank_pkg::lock_s   lock_in,
	// measurements
	input  wire limit_bank_pkg::value_t  supply_level_in,
	input  wire limit_bank_pkg::value_t  heatsink_temp_in,
	input  wire limit_bank_pkg::value_t  board_temp_in,
	// limits to the power stage
	output limit_bank_pkg::value_t      regen_cap_out,
	output limit_bank_pkg::value_t      accel_limit_out,
	output limit_bank_pkg::value_t      decel_limit_out,
	output logic                        decel_enable_out,
	// supply status
	output logic                        low_supply_out,
	output logic                        high_supply_out,
	output logic                        duty_force_zero_out
);

	// register number to threshold slot, slot 4 marks no threshold
	function automatic logic [2:0] thr_slot(input logic [3:0] ofs);
		case (ofs)
			`UV_SHUTDOWN_OFS: thr_slot = 3'd0;
			`UV_RECOVER_OFS:  thr_slot = 3'd1;
			`OV_RECOVER_OFS:  thr_slot = 3'd2;
			`OV_SHUTDOWN_OFS: thr_slot = 3'd3;
			default:          thr_slot = 3'd4;
		endcase
	endfunction

	// true when a register number exists for the given access
	function automatic logic reg_known(input logic [3:0] ofs,
		input logic wr);
		if (wr) begin
			reg_known = (ofs >= `REGEN_CAP_OFS) &&
				(ofs <= `OV_SHUTDOWN_OFS);
		end else begin
			reg_known = (ofs >= `REGEN_CAP_OFS) &&
				(ofs <= `BOARD_TEMP_OFS);
		end
	endfunction

	limit_bank_pkg::parse_state_e state_reg;
	logic [3:0]                   ofs_reg;
	logic [6:0]                   hi_reg;
	logic [6:0]                   lo_pend_reg;
	logic                         wr_pulse_reg;
	limit_bank_pkg::value_t       wr_data_reg;
	logic [3:0]                   wr_ofs_reg;

	limit_bank_pkg::value_t       thr_reg [0:3];
	logic [3:0]                   thr_written_reg;
	logic [3:0]                   thr_active;
	limit_bank_pkg::value_t       decel_next;
	limit_bank_pkg::value_t       supply_reg;
	limit_bank_pkg::value_t       heat_reg;
	limit_bank_pkg::value_t       board_reg;
	limit_bank_pkg::value_t       rd_value;
	logic [13:0]                  rd_wide;
	logic [3:0]                   cmd_ofs;
	logic                         cmd_wr;
	logic [1:0]                   pot_wr;
	limit_bank_pkg::value_t       pot_val [0:1];
	limit_bank_pkg::value_t       pot_src [0:1];
	logic [1:0]                   pot_lock;
	logic                         uv_trip;
	logic                         ov_trip;
	logic                         uv_clear;
	logic                         ov_clear;
	logic [2:0]                   thr_sel;
	logic [3:0]                   rd_ofs;
	logic [6:0]                   hi_send;
	logic [6:0]                   lo_capture;

	// fields of the command byte
	assign cmd_ofs = rx_byte_in[3:0];
	assign cmd_wr  = rx_byte_in[`CMD_WRITE_BIT];

	// command parser: command, then two data bytes for writes
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			state_reg <= limit_bank_pkg::ST_CMD;
			ofs_reg   <= 4'h0;
			hi_reg    <= 7'h00;
		end else begin
			case (state_reg)
				limit_bank_pkg::ST_CMD: begin
					if (rx_valid_in && !rx_byte_in[`BYTE_TOP_BIT] &&
						rx_byte_in[5:4] == 2'b00 &&
						reg_known(cmd_ofs, cmd_wr)) begin
						ofs_reg <= cmd_ofs;
						if (cmd_wr) begin
							state_reg <= limit_bank_pkg::ST_DATA_HI;
						end else begin
							state_reg <= limit_bank_pkg::ST_SEND_LO;
						end
					end
				end
				limit_bank_pkg::ST_DATA_HI: begin
					if (rx_valid_in) begin
						if (rx_byte_in[`BYTE_TOP_BIT]) begin
							state_reg <= limit_bank_pkg::ST_CMD;
						end else begin
							hi_reg    <= rx_byte_in[6:0];
							state_reg <= limit_bank_pkg::ST_DATA_LO;
						end
					end
				end
				limit_bank_pkg::ST_DATA_LO: begin
					if (rx_valid_in) begin
						state_reg <= limit_bank_pkg::ST_CMD;
					end
				end
				limit_bank_pkg::ST_SEND_LO: begin
					state_reg <= limit_bank_pkg::ST_CMD;
				end
				default: begin
					state_reg <= limit_bank_pkg::ST_CMD;
				end
			endcase
		end
	end

	// write strobe once the low data byte lands
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			wr_pulse_reg <= 1'b0;
			wr_data_reg  <= 12'h000;
			wr_ofs_reg   <= 4'h0;
		end else begin
			wr_pulse_reg <= 1'b0;
			if (state_reg == limit_bank_pkg::ST_DATA_LO && rx_valid_in &&
				!rx_byte_in[`BYTE_TOP_BIT]) begin
				wr_pulse_reg <= 1'b1;
				// bits 13:12 have no storage in a 12-bit register
				wr_data_reg  <= {hi_reg[4:0], rx_byte_in[6:0]};
				wr_ofs_reg   <= ofs_reg;
			end
		end
	end

	// read source: the command byte itself while it is being taken
	assign rd_ofs = (state_reg == limit_bank_pkg::ST_CMD) ? cmd_ofs : ofs_reg;

	// read value selection by register number
	always_comb begin
		case (rd_ofs)
			`REGEN_CAP_OFS:     rd_value = regen_cap_out;
			`ACCEL_RAMP_OFS:    rd_value = accel_limit_out;
			`DECEL_RAMP_OFS:    rd_value = decel_limit_out;
			`UV_SHUTDOWN_OFS:   rd_value = thr_reg[0];
			`UV_RECOVER_OFS:    rd_value = thr_reg[1];
			`OV_RECOVER_OFS:    rd_value = thr_reg[2];
			`OV_SHUTDOWN_OFS:   rd_value = thr_reg[3];
			`HEATSINK_TEMP_OFS: rd_value = heat_reg;
			`BOARD_TEMP_OFS:    rd_value = board_reg;
			default:            rd_value = 12'h000;
		endcase
	end

	assign rd_wide = {2'b00, rd_value};

	// answer: high byte right after the read command, low byte next
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			tx_byte_out  <= 8'h00;
			tx_valid_out <= 1'b0;
			lo_pend_reg  <= 7'h00;
		end else begin
			tx_valid_out <= 1'b0;
			if (state_reg == limit_bank_pkg::ST_SEND_LO) begin
				tx_byte_out  <= {1'b0, lo_pend_reg};
				tx_valid_out <= 1'b1;
			end else if (state_reg == limit_bank_pkg::ST_CMD &&
				rx_valid_in && !rx_byte_in[`BYTE_TOP_BIT] && !cmd_wr &&
				rx_byte_in[5:4] == 2'b00 && reg_known(cmd_ofs, 1'b0)) begin
				tx_valid_out <= 1'b1;
				tx_byte_out  <= {1'b0, hi_send};
				lo_pend_reg  <= lo_capture;
			end
		end
	end

	// both answer halves taken at the command, so from one sample
	assign hi_send    = rd_wide[`VAL_HI_MSB:`VAL_HI_LSB];
	assign lo_capture = rd_wide[`VAL_LO_MSB:0];

	// pot-backed limit registers, one per potentiometer
	assign pot_src[0]  = regen_pot_in;
	assign pot_src[1]  = ramp_pot_in;
	assign pot_lock[0] = lock_in.regen;
	assign pot_lock[1] = lock_in.accel;
	assign regen_cap_out   = pot_val[0];
	assign accel_limit_out = pot_val[1];

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi = gi + 1) begin : g_pot
			// write strobe aimed at this register
			assign pot_wr[gi] = wr_pulse_reg &&
				(wr_ofs_reg == (`REGEN_CAP_OFS + 4'(gi)));
			pot_tracked_reg u_pot (
				.clk_in     (clk_in),
				.rst_in     (rst_in),
				.pot_in     (pot_src[gi]),
				.lock_in    (pot_lock[gi]),
				.wr_in      (pot_wr[gi]),
				.wr_data_in (wr_data_reg),
				.value_out  (pot_val[gi])
			);
		end
	endgenerate

	// deceleration limit, enabled only by a host value of one or more
	assign decel_next = wr_data_reg;
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			decel_limit_out  <= `DECEL_RAMP_RST;
			decel_enable_out <= 1'b0;
		end else if (wr_pulse_reg && wr_ofs_reg == `DECEL_RAMP_OFS) begin
			decel_limit_out  <= decel_next;
			decel_enable_out <= (decel_next != 12'h000);
		end
	end

	// threshold slot aimed at by the pending write
	assign thr_sel = thr_slot(wr_ofs_reg);

	// supply thresholds and their written flags
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			thr_reg[0]      <= `UV_SHUTDOWN_RST;
			thr_reg[1]      <= `UV_RECOVER_RST;
			thr_reg[2]      <= `OV_RECOVER_RST;
			thr_reg[3]      <= `OV_SHUTDOWN_RST;
			thr_written_reg <= 4'h0;
		end else begin
			if (wr_pulse_reg && thr_sel != 3'd4) begin
				thr_reg[thr_sel[1:0]]         <= wr_data_reg;
				thr_written_reg[thr_sel[1:0]] <= 1'b1;
			end
			// internal ceiling overrides the high shutdown level
			if (thr_reg[3] > `OV_INTERNAL_MAX) begin
				thr_reg[3] <= `OV_INTERNAL_MAX;
			end
		end
	end

	// a threshold acts only when written and locked
	assign thr_active = thr_written_reg &
		{lock_in.ov_off, lock_in.ov_on, lock_in.uv_on, lock_in.uv_off};

	// measurement sampling, temperatures shaped to their fields
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			supply_reg <= 12'h000;
			heat_reg   <= `HEATSINK_MIN;
			board_reg  <= 12'h000;
		end else begin
			supply_reg <= supply_level_in;
			if (heatsink_temp_in < `HEATSINK_MIN) begin
				heat_reg <= `HEATSINK_MIN;
			end else if (heatsink_temp_in > `HEATSINK_MAX) begin
				heat_reg <= `HEATSINK_MAX;
			end else begin
				heat_reg <= heatsink_temp_in;
			end
			board_reg <= {5'h00, board_temp_in[6:0]};
		end
	end

	// trip and recovery conditions
	assign uv_trip  = thr_active[0] && (supply_reg < thr_reg[0]);
	assign ov_trip  = thr_active[3] && (supply_reg > thr_reg[3]);
	// without an active recover level, leave once back past the trip level
	assign uv_clear = thr_active[1] ? (supply_reg > thr_reg[1]) :
		!uv_trip;
	assign ov_clear = thr_active[2] ? (supply_reg < thr_reg[2]) :
		!ov_trip;

	// low supply state
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			low_supply_out <= 1'b0;
		end else if (uv_trip) begin
			low_supply_out <= 1'b1;
		end else if (uv_clear || !thr_active[0]) begin
			low_supply_out <= 1'b0;
		end
	end

	// high supply state
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			high_supply_out <= 1'b0;
		end else if (ov_trip) begin
			high_supply_out <= 1'b1;
		end else if (ov_clear || !thr_active[3]) begin
			high_supply_out <= 1'b0;
		end
	end

	// output stage held off while either shutdown state holds
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			duty_force_zero_out <= 1'b0;
		end else begin
			duty_force_zero_out <= (low_supply_out && !uv_clear) ||
				(high_supply_out && !ov_clear) || uv_trip || ov_trip;
		end
	end

endmodule

// ---- dv/limit_supply_bank_props.sv ----
// Purpose: port checker for the limit/supply register bank
// Assumes: one clock domain, synchronous active-high reset
// Notes:   a host write commits two cycles after its low data byte
`timescale 1ns/100ps

module limit_supply_bank_props (
	// ports of the bank being watched
	input wire logic                   clk_in,
	input wire logic                   rst_in,
	input wire logic                   rx_valid_in,
	input wire logic [7:0]             tx_byte_out,
	input wire logic                   tx_valid_out,
	input wire limit_bank_pkg::value_t regen_pot_in,
	input wire limit_bank_pkg::value_t ramp_pot_in,
	input wire limit_bank_pkg::lock_s  lock_in,
	input wire limit_bank_pkg::value_t regen_cap_out,
	input wire limit_bank_pkg::value_t accel_limit_out,
	input wire limit_bank_pkg::value_t decel_limit_out,
	input wire logic                   decel_enable_out,
	input wire logic                   low_supply_out,
	input wire logic                   high_supply_out,
	input wire logic                   duty_force_zero_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (rst_in);

	a_answer_top_zero: assert property (
		tx_valid_out |-> !tx_byte_out[7])
		else $error("answer byte with top bit set");
	a_answer_byte_pair: assert property (
		$rose(tx_valid_out) |=> tx_valid_out)
		else $error("answer without its low byte");
	a_duty_in_shutdown: assert property (
		(low_supply_out || high_supply_out) [*2] |-> duty_force_zero_out)
		else $error("duty not forced in shutdown");
	a_low_needs_lock: assert property (
		$rose(low_supply_out) |-> $past(lock_in.uv_off))
		else $error("low supply trip while unlocked");
	a_high_needs_lock: assert property (
		$rose(high_supply_out) |-> $past(lock_in.ov_off))
		else $error("high supply trip while unlocked");
	a_regen_pot_follow: assert property (
		!lock_in.regen && !rx_valid_in && !$past(rx_valid_in) &&
		$changed(regen_pot_in) |=> regen_cap_out == $past(regen_pot_in))
		else $error("regen cap missed a pot change");
	a_regen_lock_hold: assert property (
		(lock_in.regen && !rx_valid_in) [*3] |=> $stable(regen_cap_out))
		else $error("locked regen cap moved");
	a_accel_pot_follow: assert property (
		!lock_in.accel && !rx_valid_in && !$past(rx_valid_in) &&
		$changed(ramp_pot_in) |=> accel_limit_out == $past(ramp_pot_in))
		else $error("accel limit missed a pot change");
	a_decel_enable_match: assert property (
		decel_enable_out == (decel_limit_out != 12'h000))
		else $error("decel enable disagrees with limit");
endmodule

bind limit_supply_bank limit_supply_bank_props limit_supply_bank_props_i (
	.clk_in(clk_in),
	.rst_in(rst_in),
	.rx_valid_in(rx_valid_in),
	.tx_byte_out(tx_byte_out),
	.tx_valid_out(tx_valid_out),
	.regen_pot_in(regen_pot_in),
	.ramp_pot_in(ramp_pot_in),
	.lock_in(lock_in),
	.regen_cap_out(regen_cap_out),
	.accel_limit_out(accel_limit_out),
	.decel_limit_out(decel_limit_out),
	.decel_enable_out(decel_enable_out),
	.low_supply_out(low_supply_out),
	.high_supply_out(high_supply_out),
	.duty_force_zero_out(duty_force_zero_out)
);

// ---- dv/link_host_model.sv ----
// Purpose: host on the command link, sends command and data bytes
// Assumes: bytes are one-cycle strobes on the bank clock
// Notes:   idle line shows the inverse of the last byte
`timescale 1ns/100ps

module link_host_model (
	// clock
	input  wire logic clk_in,
	// bytes toward the bank
	output logic [7:0] rx_byte_out,
	output logic       rx_valid_out
);
	// idle line at time zero
	initial begin
		rx_byte_out = 8'h55;
		rx_valid_out = 1'b0;
	end

	// one byte strobe after a random gap
	task automatic put(input logic [7:0] b);
		repeat ($urandom_range(2)) @(posedge clk_in);
		@(posedge clk_in);
		#1;
		rx_byte_out = b;
		rx_valid_out = 1'b1;
		@(posedge clk_in);
		#1;
		rx_valid_out = 1'b0;
		rx_byte_out = ~b;
	endtask

	// write command, then high five and low seven bits
	task automatic write_reg(input logic [3:0] r, input logic [11:0] v);
		put({4'h4, r});
		put({3'b000, v[11:7]});
		put({1'b0, v[6:0]});
	endtask
endmodule

// ---- dv/testbench.sv ----
// Purpose: self-checking bench for the limit/supply register bank
// Assumes: host model drives the link, answers checked from a queue
// Notes:   expected answer bytes are queued before each read
`timescale 1ns/100ps
`include "limit_bank_defines.svh"

module testbench;
	logic                   clk_in;
	logic                   rst_in;
	logic [7:0]             rx_byte, tx_byte;
	logic                   rx_valid, tx_valid;
	limit_bank_pkg::value_t regen_pot, ramp_pot, supply, heat, board;
	limit_bank_pkg::value_t regen_cap, accel_lim, decel_lim, v;
	limit_bank_pkg::lock_s  lock_bits;
	logic                   decel_en, low_sup, high_sup, duty_zero;
	logic [7:0]             exp_q[$];
	int                     err_total;
	int                     checks;
	int                     sup_in[12] = '{'h100, 'ha00, 'h600, 'h400,
		'h3ff, 'h480, 'h500, 'h501, 'h900, 'h901, 'h850, 'h7ff};
	logic [2:0]             sup_ex[12] = '{0, 0, 0, 0, 5, 5, 5, 0, 0, 3, 3, 0};

	// 40 MHz clock
	initial begin
		clk_in = 1'b0;
		forever #12.5 clk_in = ~clk_in;
	end

	limit_supply_bank limit_supply_bank_i (.clk_in(clk_in), .rst_in(rst_in),
		.rx_byte_in(rx_byte), .rx_valid_in(rx_valid), .tx_byte_out(tx_byte),
		.tx_valid_out(tx_valid), .regen_pot_in(regen_pot),
		.ramp_pot_in(ramp_pot), .lock_in(lock_bits), .supply_level_in(supply),
		.heatsink_temp_in(heat), .board_temp_in(board),
		.regen_cap_out(regen_cap), .accel_limit_out(accel_lim),
		.decel_limit_out(decel_lim), .decel_enable_out(decel_en),
		.low_supply_out(low_sup), .high_supply_out(high_sup),
		.duty_force_zero_out(duty_zero));

	link_host_model link_host_model_i (.clk_in(clk_in),
		.rx_byte_out(rx_byte), .rx_valid_out(rx_valid));

	task automatic fail(input string m);
		err_total++;
		$display("unexpected at %0t: %s", $time, m);
	endtask

	task automatic chk(input limit_bank_pkg::value_t got, exp);
		checks++;
		if (got !== exp) fail($sformatf("got %h want %h", got, exp));
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask

	// queue both answer bytes, then send the read command
	task automatic rd(input logic [3:0] r, input limit_bank_pkg::value_t e);
		exp_q.push_back({3'b000, e[11:7]});
		exp_q.push_back({1'b0, e[6:0]});
		link_host_model_i.put({4'h0, r});
		tick(4);
	endtask

	task automatic final_report();
		$display("checks %0d err_total %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// answer watcher takes the oldest queued byte
	always @(posedge clk_in) begin
		if (tx_valid === 1'b1) begin
			checks++;
			if (exp_q.size() == 0) fail("answer with none pending");
			else if (tx_byte !== exp_q.pop_front()) fail("answer byte");
		end
	end

	// watchdog
	initial begin
		#(25 * 20000);
		fail("watchdog");
		final_report();
	end

	// main sequence
	initial begin
		void'($urandom(32'h9b45));
		rst_in = 1'b1;
		lock_bits = '0;
		supply = 12'h600;
		heat = 12'd40;
		board = 12'h1ff;
		regen_pot = 12'($urandom_range(4095));
		ramp_pot = 12'($urandom_range(4095));
		tick(5);
		rst_in = 1'b0;
		tick(2);
		chk(regen_cap, regen_pot);
		chk(accel_lim, ramp_pot);
		chk({11'h0, decel_en}, 12'h000);
		rd(4'h5, `DECEL_RAMP_RST);
		rd(4'h6, `UV_SHUTDOWN_RST);
		rd(4'h7, `UV_RECOVER_RST);
		rd(4'h8, `OV_RECOVER_RST);
		rd(4'h9, `OV_SHUTDOWN_RST);
		for (int k = 0; k < 2; k++) begin
			v = 12'($urandom_range(4095));
			link_host_model_i.write_reg(4'(3 + k), v);
			tick(3);
			rd(4'(3 + k), v);
			chk(k ? accel_lim : regen_cap, v);
			regen_pot = regen_pot + 12'h001;
			ramp_pot = ramp_pot + 12'h001;
			tick(2);
			chk(k ? accel_lim : regen_cap, k ? ramp_pot : regen_pot);
		end
		lock_bits.regen = 1'b1;
		lock_bits.accel = 1'b1;
		tick(2);
		v = regen_pot;
		regen_pot = regen_pot + 12'h010;
		ramp_pot = ramp_pot + 12'h010;
		tick(3);
		chk(regen_cap, v);
		chk(accel_lim, ramp_pot - 12'h010);
		link_host_model_i.write_reg(4'h5, 12'h001);
		tick(3);
		chk(decel_lim, 12'h001);
		chk({11'h0, decel_en}, 12'h001);
		link_host_model_i.put(8'h45);
		link_host_model_i.put(8'h00);
		link_host_model_i.put(8'h85);
		tick(3);
		chk(decel_lim, 12'h001);
		link_host_model_i.write_reg(4'ha, 12'h001);
		link_host_model_i.put(8'h0c);
		tick(4);
		heat = 12'd5;
		tick(2);
		rd(4'ha, `HEATSINK_MIN);
		heat = 12'd200;
		tick(2);
		rd(4'ha, `HEATSINK_MAX);
		rd(4'hb, 12'h07f);
		link_host_model_i.write_reg(4'h6, 12'h400);
		link_host_model_i.write_reg(4'h7, 12'h500);
		link_host_model_i.write_reg(4'h8, 12'h800);
		link_host_model_i.write_reg(4'h9, 12'h900);
		for (int i = 0; i < 12; i++) begin
			if (i == 2) lock_bits = '1;
			supply = 12'(sup_in[i]);
			tick(3);
			chk({11'h0, low_sup}, {11'h0, sup_ex[i][2]});
			chk({11'h0, high_sup}, {11'h0, sup_ex[i][1]});
			chk({11'h0, duty_zero}, {11'h0, sup_ex[i][0]});
		end
		link_host_model_i.write_reg(4'h9, 12'hfff);
		tick(3);
		rd(4'h9, `OV_INTERNAL_MAX);
		rst_in = 1'b1;
		tick(2);
		rst_in = 1'b0;
		tick(2);
		chk(regen_cap, regen_pot);
		rd(4'h5, `DECEL_RAMP_RST);
		tick(10);
		if (exp_q.size() != 0) fail("answers missing");
		final_report();
	end
endmodule
